// file: bfs_pkg.sv
/*
 * Constants, types and command codes shared by the buck fault supervisor.
 * Assumes a 100 MHz core clock; every time is derived from that rate.
 */
`default_nettype none
package bfs_pkg;
	localparam logic [7:0] CMD_OPERATION      = 8'h01;
	localparam logic [7:0] CMD_ON_OFF_CONFIG  = 8'h02;
	localparam logic [7:0] CMD_CLEAR_FAULTS   = 8'h03;
	localparam logic [7:0] CMD_STATUS_BYTE    = 8'h78;
	localparam logic [7:0] CMD_OUTPUT_CURRENT = 8'h8C;
	localparam logic [7:0] CMD_FAULT_RESPONSE = 8'hD3;

	localparam logic [7:0] OPERATION_RESET    = 8'h80;
	localparam logic [7:0] ON_OFF_RESET       = 8'h1F;
	localparam logic [7:0] ON_OFF_FIXED       = 8'h13;
	localparam logic [7:0] ON_OFF_WRITE_MASK  = 8'h0C;
	localparam logic [7:0] OPERATION_MASK     = 8'h8F;
	localparam logic [15:0] CURRENT_RESET     = 16'h0000;
	localparam logic [7:0] STATUS_RESET       = 8'h00;

	localparam int OP_ON_BIT      = 7;
	localparam int CFG_OP_BIT     = 3;
	localparam int CFG_PIN_BIT    = 2;
	localparam int RETRY_BIT      = 0;
	localparam int STS_OFF_BIT    = 6;
	localparam int STS_OV_BIT     = 5;
	localparam int STS_OC_BIT     = 4;
	localparam int STS_UV_BIT     = 3;
	localparam int STS_OT_BIT     = 2;
	localparam int STS_UVLO_BIT   = 1;

	localparam int CLK_MHZ               = 100;
	localparam int TELEMETRY_US          = 108;
	localparam int OC_BLANK_US           = 128;
	localparam int SHORT_FILTER_NS       = 50;
	localparam int HICCUP_US             = 9000;
	localparam int STARTUP_OV_ARM_US     = 5500;
	localparam int STARTUP_OV_ARM_MAX_US = 6500;
	localparam int SOFTSTART_US          = 1000;

	localparam int TELEMETRY_CYC  = TELEMETRY_US * CLK_MHZ;
	localparam int OC_BLANK_CYC   = OC_BLANK_US * CLK_MHZ;
	localparam int SHORT_FILT_CYC = (SHORT_FILTER_NS * CLK_MHZ + 999) / 1000;
	localparam int HICCUP_CYC     = HICCUP_US * CLK_MHZ;
	localparam int OV_ARM_CYC     = STARTUP_OV_ARM_US * CLK_MHZ;
	localparam int OV_ARM_MAX_CYC = STARTUP_OV_ARM_MAX_US * CLK_MHZ;
	localparam int SOFTSTART_CYC  = SOFTSTART_US * CLK_MHZ;
	localparam int TW             = 24;

	typedef enum logic [2:0] {
		ST_OFF       = 3'b000,
		ST_SOFTSTART = 3'b001,
		ST_REGULATE  = 3'b010,
		ST_HICCUP    = 3'b011,
		ST_LATCHED   = 3'b100
	} bfs_state_t;

	typedef struct packed {
		logic rails_por_ok;
		logic vin_uvlo;
		logic bias_uvlo;
		logic ot_trip;
		logic ot_release;
		logic ov_rising;
		logic ov_below_falling;
		logic startup_ov;
		logic uv_below;
		logic oc_average;
		logic oc_peak;
	} bfs_sense_t;
endpackage : bfs_pkg
`default_nettype wire

// file: bfs_supervisor.sv
/*
 * Fault supervisor: fault detection, latch and hiccup handling, gate
 * forcing, power-good and output-current telemetry capture.
 * Assumes analog comparators and the current ADC sit outside, delivering
 * synchronous digital levels, and that the serial bus engine hands over
 * decoded command bytes one per cmd_valid pulse.
 */
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Start a current conversion every 108 us and store it at 8Ch.
// - Input, bias undervoltage and over-temperature shut down and self-recover.
// - Overvoltage and undervoltage latch until supply, enable or command clears.
// - Output above 120 percent latches off with power-good low.
// - Latched overvoltage toggles low-side gate between 120 and 100 percent.
// - Start-up overvoltage check armed 5.5 ms after power-on until soft-start ends.
// - Output under 74 percent latches off, both gates low, power-good low.
// - Average overcurrent faults only after persisting 128 us blanking.
// - Short-circuit at 130 percent faults after a 50 ns filter.
// - Overcurrent forces gates low, then latches or retries per strap or bit 0.
// - Retry mode waits 9 ms hiccup then restarts.
// - Thermistor trip below 22.31 percent, release above 27.79 percent.
// - Power-good low on any fault; high only when regulating.
// - Config bits 3 and 2 let command and enable pin control and clear.
// - Operation bit 7 turns off or on; toggling clears when permitted.
// - Send-byte 03h clears all status fault bits.
module bfs_supervisor
	import bfs_pkg::*;
#(
	parameter int unsigned TELEMETRY_CYCLES = TELEMETRY_CYC,
	parameter int unsigned OC_BLANK_CYCLES  = OC_BLANK_CYC,
	parameter int unsigned HICCUP_CYCLES    = HICCUP_CYC,
	parameter int unsigned OV_ARM_CYCLES    = OV_ARM_CYC,
	parameter int unsigned SOFTSTART_CYCLES = SOFTSTART_CYC
)
(
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic        clock_enable,
	input  wire bfs_sense_t  sense,
	input  wire logic        enable_pin,
	input  wire logic        fault_mode_strap_pin,
	input  wire logic        pwm_high_request,
	input  wire logic        pwm_low_request,
	input  wire logic        adc_done,
	input  wire logic [15:0] adc_code,
	input  wire logic        cmd_valid,
	input  wire logic        cmd_write,
	input  wire logic [7:0]  cmd_code,
	input  wire logic [7:0]  cmd_data,
	output logic             adc_start,
	output logic             high_side_gate_drive,
	output logic             low_side_gate_drive,
	output logic             power_good_output,
	output logic             rsp_valid,
	output logic             rsp_error,
	output logic [15:0]      rsp_data
);
	bfs_state_t        state;
	bfs_state_t        next_state;
	logic [TW-1:0]     state_timer;
	logic [TW-1:0]     por_timer;
	logic [TW-1:0]     tele_timer;
	logic [TW-1:0]     blank_timer;
	logic [2:0]        filt_count;
	logic [7:0]        operation;
	logic [7:0]        on_off_config;
	logic [7:0]        fault_response;
	logic [7:0]        status_byte;
	logic [15:0]       output_current_reading;
	logic              strap_taken;
	logic              enable_seen;
	logic              ot_active;
	logic              ov_latched;
	logic              ov_discharge;

	// Decoded commands
	wire wr_op    = cmd_valid && cmd_write && cmd_code == CMD_OPERATION;
	wire wr_cfg   = cmd_valid && cmd_write && cmd_code == CMD_ON_OFF_CONFIG;
	wire wr_resp  = cmd_valid && cmd_write && cmd_code == CMD_FAULT_RESPONSE;
	wire clr_cmd  = cmd_valid && cmd_write && cmd_code == CMD_CLEAR_FAULTS;
	wire cmd_read = cmd_valid && !cmd_write;

	// Control sources and latch clearing
	wire op_allowed  = on_off_config[CFG_OP_BIT];
	wire pin_allowed = on_off_config[CFG_PIN_BIT];
	wire op_on       = !op_allowed || operation[OP_ON_BIT];
	wire pin_on      = !pin_allowed || enable_pin;
	wire on_request  = op_on && pin_on;
	wire op_toggle   = wr_op && cmd_data[OP_ON_BIT] && !operation[OP_ON_BIT];
	wire pin_rise    = enable_pin && enable_seen;
	wire clear_latch = (op_allowed && op_toggle) ||
		(pin_allowed && pin_rise) || !sense.rails_por_ok;

	// Self-recovering faults; comparator pair gives the thermal hysteresis
	wire uvlo      = sense.vin_uvlo || sense.bias_uvlo || !sense.rails_por_ok;
	// Trip acts in its own cycle; the flag only carries the hysteresis
	wire ot_level  = sense.ot_trip || ot_active;
	wire shutdown  = uvlo || ot_level;

	// Overcurrent qualification
	wire oc_avg_fault = sense.oc_average &&
		blank_timer == TW'(OC_BLANK_CYCLES - 1);
	wire short_fault  = sense.oc_peak &&
		filt_count == 3'(SHORT_FILT_CYC - 1);
	wire oc_fault     = oc_avg_fault || short_fault;
	wire retry_mode   = fault_response[RETRY_BIT];

	// Start-up overvoltage window: armed after the power-on delay, in soft-start
	wire ov_armed     = por_timer == TW'(OV_ARM_CYCLES);
	wire startup_ovf  = state == ST_SOFTSTART && ov_armed &&
		sense.startup_ov;
	wire run_ovf      = state == ST_REGULATE && sense.ov_rising;
	wire ov_fault     = startup_ovf || run_ovf;
	wire uv_fault     = state == ST_REGULATE && sense.uv_below;
	wire ss_done      = state_timer == TW'(SOFTSTART_CYCLES - 1);
	wire hiccup_done  = state_timer == TW'(HICCUP_CYCLES - 1);
	wire switching    = next_state == ST_SOFTSTART ||
		next_state == ST_REGULATE;
	wire tele_tick    = tele_timer == TW'(TELEMETRY_CYCLES - 1);
	// Looked at before they land, so the clamp starts with the latch itself
	wire next_ov_latched   = next_state == ST_LATCHED &&
		(state == ST_LATCHED ? ov_latched : ov_fault);
	wire next_ov_discharge = sense.ov_rising ||
		(ov_discharge && !sense.ov_below_falling);

	wire [7:0] fault_events = {1'b0, !on_request, ov_fault, oc_fault,
		uv_fault, ot_level, uvlo, 1'b0};
	wire [7:0] op_next  = wr_op ? (cmd_data & OPERATION_MASK) : operation;
	wire [7:0] cfg_next = wr_cfg ?
		(ON_OFF_FIXED | (cmd_data & ON_OFF_WRITE_MASK)) : on_off_config;

	// Latched fault states only leave through an allowed clear
	always_comb
	begin
		next_state = state;
		unique case (state)
			ST_OFF:
				if (on_request && !shutdown)
					next_state = ST_SOFTSTART;
			ST_SOFTSTART, ST_REGULATE:
				if (shutdown || !on_request)
					next_state = ST_OFF;
				else if (ov_fault || uv_fault)
					next_state = ST_LATCHED;
				else if (oc_fault)
					next_state = retry_mode ? ST_HICCUP : ST_LATCHED;
				else if (state == ST_SOFTSTART && ss_done)
					next_state = ST_REGULATE;
			ST_HICCUP:
				if (shutdown || !on_request)
					next_state = ST_OFF;
				else if (hiccup_done)
					next_state = ST_SOFTSTART;
			ST_LATCHED:
				if (clear_latch)
					next_state = ST_OFF;
			default:
				next_state = ST_OFF;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			state       <= ST_OFF;
			state_timer <= '0;
		end
		else if (clock_enable)
		begin
			state       <= next_state;
			state_timer <= (next_state != state) ? '0 : state_timer + 1'b1;
		end
	end

	// Power-on delay counts only while every rail is above its reset level
	always_ff @(posedge clock)
	begin
		if (reset)
			por_timer <= '0;
		else if (clock_enable)
		begin
			if (!sense.rails_por_ok)
				por_timer <= '0;
			else if (!ov_armed)
				por_timer <= por_timer + 1'b1;
		end
	end

	// Blanking restarts on any dip, so only a persistent excess counts
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			blank_timer <= '0;
			filt_count  <= '0;
		end
		else if (clock_enable)
		begin
			if (!sense.oc_average || oc_avg_fault)
				blank_timer <= '0;
			else
				blank_timer <= blank_timer + 1'b1;
			if (!sense.oc_peak || short_fault)
				filt_count <= '0;
			else
				filt_count <= filt_count + 1'b1;
		end
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			ot_active    <= 1'b0;
			ov_latched   <= 1'b0;
			ov_discharge <= 1'b0;
			enable_seen  <= 1'b0;
		end
		else if (clock_enable)
		begin
			if (sense.ot_trip)
				ot_active <= 1'b1;
			else if (sense.ot_release)
				ot_active <= 1'b0;
			ov_latched   <= next_ov_latched;
			ov_discharge <= next_ov_discharge;
			enable_seen <= !enable_pin;
		end
	end

	// Gates follow next_state, so a fault forces them in its own cycle
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			high_side_gate_drive <= 1'b0;
			low_side_gate_drive  <= 1'b0;
			power_good_output    <= 1'b0;
		end
		else if (clock_enable)
		begin
			high_side_gate_drive <= switching && pwm_high_request;
			low_side_gate_drive  <= switching ? pwm_low_request :
				next_ov_latched && next_ov_discharge;
			power_good_output    <= next_state == ST_REGULATE &&
				state == ST_REGULATE && !shutdown;
		end
	end

	// Telemetry: the ADC answers asynchronously, last result wins
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			tele_timer             <= '0;
			adc_start              <= 1'b0;
			output_current_reading <= CURRENT_RESET;
		end
		else if (clock_enable)
		begin
			tele_timer <= tele_tick ? '0 : tele_timer + 1'b1;
			adc_start  <= tele_tick;
			if (adc_done)
				output_current_reading <= adc_code;
		end
	end

	// Strap is caught on the first enabled cycle after reset
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			operation      <= OPERATION_RESET;
			on_off_config  <= ON_OFF_RESET;
			fault_response <= 8'h00;
			strap_taken    <= 1'b0;
			status_byte    <= STATUS_RESET;
		end
		else if (clock_enable)
		begin
			operation     <= op_next;
			on_off_config <= cfg_next;
			strap_taken   <= 1'b1;
			if (!strap_taken)
				fault_response <= {7'h00, fault_mode_strap_pin};
			else if (wr_resp)
				fault_response <= {7'h00, cmd_data[RETRY_BIT]};
			// A fault arriving with the clear stays set
			status_byte <= (clr_cmd ? 8'h00 : status_byte) |
				fault_events;
		end
	end

	wire known_read = cmd_code == CMD_OPERATION ||
		cmd_code == CMD_ON_OFF_CONFIG || cmd_code == CMD_STATUS_BYTE ||
		cmd_code == CMD_OUTPUT_CURRENT || cmd_code == CMD_FAULT_RESPONSE;
	wire known_write = cmd_code == CMD_OPERATION ||
		cmd_code == CMD_ON_OFF_CONFIG || cmd_code == CMD_CLEAR_FAULTS ||
		cmd_code == CMD_FAULT_RESPONSE;
	wire [15:0] read_mux =
		cmd_code == CMD_OPERATION      ? {8'h00, operation} :
		cmd_code == CMD_ON_OFF_CONFIG  ? {8'h00, on_off_config} :
		cmd_code == CMD_STATUS_BYTE    ? {8'h00, status_byte} :
		cmd_code == CMD_OUTPUT_CURRENT ? output_current_reading :
		cmd_code == CMD_FAULT_RESPONSE ? {8'h00, fault_response} : 16'h0000;

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			rsp_valid <= 1'b0;
			rsp_error <= 1'b0;
			rsp_data  <= 16'h0000;
		end
		else if (clock_enable)
		begin
			rsp_valid <= cmd_valid;
			rsp_error <= cmd_valid &&
				(cmd_write ? !known_write : !known_read);
			if (cmd_read)
				rsp_data <= read_mux;
		end
	end
endmodule : bfs_supervisor
`default_nettype wire

// file: bfs_checker.sv
/* Port-level checks for the buck fault supervisor.
   Assumes clock_enable is held high while these checks run. */
`timescale 1ns/100ps
`default_nettype none
module bfs_checker
	import bfs_pkg::*;
#(
	parameter int unsigned TELEMETRY_CYCLES = 20,
	parameter int unsigned OC_BLANK_CYCLES  = 16
)
(
	input wire logic       clock,
	input wire logic       reset,
	input wire bfs_sense_t sense,
	input wire logic       cmd_valid,
	input wire logic       cmd_write,
	input wire logic [7:0] cmd_code,
	input wire logic       adc_start,
	input wire logic       high_side_gate_drive,
	input wire logic       low_side_gate_drive,
	input wire logic       power_good_output,
	input wire logic       rsp_valid,
	input wire logic       rsp_error
);
	logic [7:0]    oc_run;
	logic [TW-1:0] tel_gap;
	logic          tel_seen;
	wire tel_due   = tel_gap == TW'(TELEMETRY_CYCLES - 1);
	wire rd_clear  = cmd_valid && !cmd_write && cmd_code == CMD_CLEAR_FAULTS;
	wire uvlo_in   = sense.vin_uvlo || sense.bias_uvlo;
	wire pg_off    = !power_good_output;
	wire hs_pg_off = !high_side_gate_drive && pg_off;
	wire all_off   = hs_pg_off && !low_side_gate_drive;
	wire ov_clamp  = low_side_gate_drive && hs_pg_off;
	wire ov_run    = power_good_output && sense.ov_rising;
	wire uv_run    = power_good_output && sense.uv_below && !sense.ov_rising;
	wire short_run = sense.oc_peak && power_good_output;
	wire oc_long   = oc_run >= OC_BLANK_CYCLES;
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	// Saturates so a stuck overload never wraps back to zero
	always_ff @(posedge clock)
		if (reset || !sense.oc_average)
			oc_run <= 8'h00;
		else if (oc_run != 8'hFF)
			oc_run <= oc_run + 8'h01;
	// A counter instead of a delay: the real period is far too long to unroll
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			tel_gap  <= '0;
			tel_seen <= 1'b0;
		end
		else
		begin
			tel_gap  <= adc_start ? '0 : tel_gap + 1'b1;
			tel_seen <= tel_seen || adc_start;
		end
	end
	a_tel_period: assert property (tel_seen |-> adc_start == tel_due)
		else $error("telemetry start period wrong");
	a_rsp_next: assert property (cmd_valid |=> rsp_valid)
		else $error("command not answered next cycle");
	a_clear_read_err: assert property (rd_clear |=> rsp_error)
		else $error("read of clear code not refused");
	a_uvlo_down: assert property (uvlo_in |=> hs_pg_off)
		else $error("undervoltage lockout left converter up");
	a_ot_gates: assert property (sense.ot_trip |=> all_off)
		else $error("over-temperature gates not forced");
	a_ov_low_on: assert property (ov_run |=> ov_clamp)
		else $error("overvoltage response wrong");
	a_uv_latch: assert property (uv_run |=> all_off)
		else $error("undervoltage response wrong");
	a_oc_blank: assert property (oc_long |-> pg_off)
		else $error("overcurrent not taken after blanking");
	a_short_filter: assert property (short_run [*5] |=> pg_off)
		else $error("short circuit not taken after filter");
	c_pg_drop: cover property (power_good_output ##1 !power_good_output);
	c_refused: cover property (rsp_valid && rsp_error);
	c_tel: cover property (adc_start);
endmodule : bfs_checker
bind bfs_supervisor bfs_checker #(.TELEMETRY_CYCLES(TELEMETRY_CYCLES),
	.OC_BLANK_CYCLES(OC_BLANK_CYCLES)) chk (.clock(clock), .reset(reset),
	.sense(sense), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
	.cmd_code(cmd_code), .adc_start(adc_start),
	.high_side_gate_drive(high_side_gate_drive),
	.low_side_gate_drive(low_side_gate_drive),
	.power_good_output(power_good_output), .rsp_valid(rsp_valid),
	.rsp_error(rsp_error));
`default_nettype wire

// file: bfs_adc_model.sv
/* Behavioural current converter on the far side of the telemetry port.
   Assumes start pulses from the supervisor; slow selects a long convert. */
`timescale 1ns/100ps
`default_nettype none
module bfs_adc_model
(
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic        adc_start,
	input  wire logic        slow,
	input  wire logic [15:0] level,
	output logic             adc_done,
	output logic [15:0]      adc_code
);
	logic [3:0] wait_cnt;
	always_ff @(posedge clock)
	begin
		adc_done <= 1'b0;
		if (reset)
			wait_cnt <= 4'h0;
		else if (adc_start)
			wait_cnt <= slow ? 4'hA : 4'h1;
		else if (wait_cnt != 4'h0)
			wait_cnt <= wait_cnt - 4'h1;
		// Code is only good with done; garbage elsewhere exposes late capture
		if (reset)
			adc_code <= 16'h5A5A;
		else if (wait_cnt == 4'h1)
			adc_code <= level;
		else
			adc_code <= ~adc_code;
		if (!reset && wait_cnt == 4'h1)
			adc_done <= 1'b1;
	end
endmodule : bfs_adc_model
`default_nettype wire

// file: testbench.sv
/* Self-checking bench for the buck fault supervisor with a converter model.
   Assumes shortened timer parameters so the run stays brief. */
`timescale 1ns/100ps
`default_nettype none
module testbench
	import bfs_pkg::*;
;
	logic clock = 1'b0, reset = 1'b1, enable_pin = 1'b1, slow = 1'b0;
	logic cmd_valid = 1'b0, cmd_write = 1'b0;
	logic [7:0] cmd_code = 8'h00, cmd_data = 8'h00;
	logic [15:0] level = 16'h1234, rd, adc_code, rsp_data;
	logic clock_enable = 1'b1, strap = 1'b0, pwm_hi = 1'b1, pwm_lo = 1'b0;
	bfs_sense_t sense = 11'h450;
	logic adc_start, adc_done, hs, ls, pg, rsp_valid, rsp_error;
	int fail_count = 0, checked = 0, cycles = 0;
	bfs_supervisor #(.TELEMETRY_CYCLES(20), .OC_BLANK_CYCLES(16),
		.HICCUP_CYCLES(40), .OV_ARM_CYCLES(30), .SOFTSTART_CYCLES(25)) uut (
		.clock(clock), .reset(reset), .clock_enable(clock_enable),
		.sense(sense), .enable_pin(enable_pin),
		.fault_mode_strap_pin(strap),
		.pwm_high_request(pwm_hi), .pwm_low_request(pwm_lo),
		.adc_done(adc_done), .adc_code(adc_code), .cmd_valid(cmd_valid),
		.cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_data(cmd_data),
		.adc_start(adc_start), .high_side_gate_drive(hs),
		.low_side_gate_drive(ls), .power_good_output(pg),
		.rsp_valid(rsp_valid), .rsp_error(rsp_error), .rsp_data(rsp_data));
	bfs_adc_model adc (.clock(clock), .reset(reset), .adc_start(adc_start),
		.slow(slow), .level(level), .adc_done(adc_done), .adc_code(adc_code));
	always #5 clock = ~clock;
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			fail_count++;
			report_and_stop();
		end
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : cyc
	// Output trio packed as {high gate, low gate, power good}
	task automatic outs(input logic [2:0] exp);
		check({13'h0000, hs, ls, pg}, {13'h0000, exp});
	endtask : outs
	task automatic cmd(input logic wr, input logic [7:0] code,
		input logic [7:0] data, input logic err);
		@(posedge clock);
		cmd_valid <= 1'b1;
		cmd_write <= wr;
		cmd_code <= code;
		cmd_data <= data;
		@(posedge clock);
		cmd_valid <= 1'b0;
		#1;
		check({14'h0000, rsp_valid, rsp_error}, {14'h0000, 1'b1, err});
		rd = rsp_data;
	endtask : cmd
	task automatic rdchk(input logic [7:0] code, input logic [15:0] exp);
		cmd(1'b0, code, 8'h00, 1'b0);
		check(rd, exp);
	endtask : rdchk
	// Bounded wait; the bound is only a timeout with slack, not the figure being checked
	task automatic wait_pg(input int max);
		int n;
		n = 0;
		while (pg !== 1'b1 && n < max)
		begin
			cyc(1);
			n++;
		end
		outs(3'b101);
	endtask : wait_pg
	task automatic en_toggle;
		@(posedge clock) enable_pin <= 1'b0;
		@(posedge clock) enable_pin <= 1'b1;
	endtask : en_toggle
	task automatic s_regs;
		rdchk(CMD_OPERATION, 16'h0080);
		rdchk(CMD_ON_OFF_CONFIG, 16'h001F);
		rdchk(CMD_FAULT_RESPONSE, 16'h0000);
		rdchk(CMD_STATUS_BYTE, 16'h0000);
		cmd(1'b0, CMD_CLEAR_FAULTS, 8'h00, 1'b1);
		cmd(1'b1, CMD_OUTPUT_CURRENT, 8'h00, 1'b1);
		cmd(1'b1, 8'h55, 8'h00, 1'b1);
		wait_pg(60);
	endtask : s_regs
	task automatic s_tel;
		@(posedge clock) level <= 16'hBEEF;
		slow <= 1'b1;
		cyc(45);
		rdchk(CMD_OUTPUT_CURRENT, 16'hBEEF);
		@(posedge clock) level <= 16'hC0DE;
		slow <= 1'b0;
		cyc(25);
		rdchk(CMD_OUTPUT_CURRENT, 16'hC0DE);
	endtask : s_tel
	task automatic s_uv;
		@(posedge clock) sense.uv_below <= 1'b1;
		@(posedge clock) sense.uv_below <= 1'b0;
		#1;
		outs(3'b000);
		cyc(60);
		outs(3'b000);
		rdchk(CMD_STATUS_BYTE, 16'h0008);
		cmd(1'b1, CMD_CLEAR_FAULTS, 8'h00, 1'b0);
		rdchk(CMD_STATUS_BYTE, 16'h0000);
		en_toggle();
		wait_pg(40);
	endtask : s_uv
	task automatic s_ov;
		@(posedge clock) sense.ov_rising <= 1'b1;
		sense.ov_below_falling <= 1'b0;
		cyc(1);
		outs(3'b010);
		@(posedge clock) sense.ov_rising <= 1'b0;
		cyc(3);
		outs(3'b010);
		@(posedge clock) sense.ov_below_falling <= 1'b1;
		cyc(1);
		outs(3'b000);
		@(posedge clock) sense.ov_below_falling <= 1'b0;
		sense.ov_rising <= 1'b1;
		cyc(1);
		outs(3'b010);
		@(posedge clock) sense.ov_rising <= 1'b0;
		sense.ov_below_falling <= 1'b1;
		cmd(1'b1, CMD_OPERATION, 8'h00, 1'b0);
		cmd(1'b1, CMD_OPERATION, 8'h80, 1'b0);
		wait_pg(40);
	endtask : s_ov
	task automatic s_oc;
		cmd(1'b1, CMD_ON_OFF_CONFIG, 8'h17, 1'b0);
		rdchk(CMD_ON_OFF_CONFIG, 16'h0017);
		@(posedge clock) sense.oc_average <= 1'b1;
		cyc(15);
		outs(3'b101);
		cyc(1);
		outs(3'b000);
		@(posedge clock) sense.oc_average <= 1'b0;
		cyc(50);
		outs(3'b000);
		cmd(1'b1, CMD_OPERATION, 8'h00, 1'b0);
		cmd(1'b1, CMD_OPERATION, 8'h80, 1'b0);
		cyc(30);
		outs(3'b000);
		en_toggle();
		wait_pg(40);
		cmd(1'b1, CMD_ON_OFF_CONFIG, 8'h1F, 1'b0);
	endtask : s_oc
	task automatic s_retry;
		cmd(1'b1, CMD_FAULT_RESPONSE, 8'h01, 1'b0);
		@(posedge clock) sense.oc_peak <= 1'b1;
		cyc(4);
		outs(3'b101);
		cyc(1);
		outs(3'b000);
		@(posedge clock) sense.oc_peak <= 1'b0;
		cyc(38);
		outs(3'b000);
		cyc(1);
		outs(3'b100);
		wait_pg(30);
	endtask : s_retry
	task automatic s_startup;
		@(posedge clock) pwm_lo <= 1'b1;
		pwm_hi <= 1'b0;
		cyc(2);
		outs(3'b011);
		@(posedge clock) pwm_lo <= 1'b0;
		pwm_hi <= 1'b1;
		@(posedge clock) sense.startup_ov <= 1'b1;
		cyc(5);
		outs(3'b101);
		en_toggle();
		cyc(4);
		outs(3'b000);
		@(posedge clock) sense.startup_ov <= 1'b0;
		cyc(20);
		outs(3'b000);
		@(posedge clock) sense.rails_por_ok <= 1'b0;
		cyc(3);
		outs(3'b000);
		@(posedge clock) sense.rails_por_ok <= 1'b1;
		wait_pg(40);
	endtask : s_startup
	task automatic s_ot_uvlo;
		@(posedge clock) sense.ot_trip <= 1'b1;
		sense.ot_release <= 1'b0;
		@(posedge clock) sense.ot_trip <= 1'b0;
		#1;
		outs(3'b000);
		cyc(40);
		outs(3'b000);
		@(posedge clock) sense.ot_release <= 1'b1;
		wait_pg(40);
		for (int i = 0; i < 2; i++)
		begin
			@(posedge clock) {sense.vin_uvlo, sense.bias_uvlo} <= i ? 2'b01 : 2'b10;
			cyc(10);
			outs(3'b000);
			@(posedge clock) {sense.vin_uvlo, sense.bias_uvlo} <= 2'b00;
			wait_pg(40);
		end
	endtask : s_ot_uvlo
	initial
	begin
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		s_regs();
		s_tel();
		s_uv();
		s_ov();
		s_oc();
		s_retry();
		s_ot_uvlo();
		s_startup();
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire
